// file: logic/pss_sequencer.sv
`timescale 1ns/1ps
`include "pss_cfg.svh"
// Summary of operation
// - valid input starts nominal 20 ms turn-on delay
// - faults masked in delay; close only if clean
// - brownout opens switch, enables discharge
// - brownout clear: discharge off, recovery delay, reclose
// - fault opens enable discharge except OV/thermal/short
// - brownout, thermistor, request faults enable discharge
// - input discharge follows output discharge
// - discharge on battery select below rising level
// - prefer input above switch-over, else battery
// - falling to battery clears request latch
// - switch functions only with input present
// - request held debounce time latches with input
// - latch persists until input power-cycled
// - battery only: unlatched open and disconnect
// - battery only: request low releases disconnect
// - disconnect only for thermistor or request
// - disconnect falls 500 ms after alert rises
// - thermistor release debounced 50 ms on input, one clean sample on battery
// - on battery check every 2.5 s, bias 5 ms, sample 1.6 ms; on input every tick from 1.6 ms into each 2.5 s period
// - thermistor hot drives alert, then opens switch
// - bias rail duty-cycled only on battery
module pss_sequencer #(
   parameter int TICK_CYC = `PSS_TICK_CYC,
   parameter int TICK_US = `PSS_TICK_US
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // analog comparator results; vin_valid already carries switch-over hysteresis
   input wire pss_pkg::pss_sense_s sense,
   input wire logic thermistor_inputs,
   // shared alert / request pin
   input wire logic alert_pin_in,
   output logic alert_pin_out,
   output logic alert_pin_oe,
   // battery disconnect, open drain
   output logic battery_disconnect_n_out,
   output logic battery_disconnect_n_oe,
   // power controls
   output logic switch_close,
   output logic inrush_limit,
   output logic out_discharge,
   output logic in_discharge,
   output logic sensor_bias_rail,
   output logic battery_selected
);
   localparam int TON_T = `PSS_TON_MS * 1000 / TICK_US;
   localparam int REC_T = `PSS_REC_MS * 1000 / TICK_US;
   localparam int KILL_T = `PSS_KILL_MS * 1000 / TICK_US;
   localparam int ALERT_T = `PSS_ALERT_MS * 1000 / TICK_US;
   localparam int REL_T = `PSS_REL_MS * 1000 / TICK_US;
   localparam int PER_T = `PSS_PERIOD_US / TICK_US;
   localparam int BIAS_T = `PSS_BIAS_ON_US / TICK_US;
   localparam int SET_T = (`PSS_SETTLE_US + TICK_US - 1) / TICK_US;
   localparam int CW = 16;

   // timebase
   logic [CW-1:0] pre_ff, nxt_pre;
   logic tick_ff, nxt_tick;
   // sequencer
   pss_pkg::pss_state_e st_ff, nxt_st;
   logic [CW-1:0] seq_cnt_ff, nxt_seq_cnt;
   logic was_brownout_ff, nxt_was_brownout;
   // request / thermal
   logic [CW-1:0] kill_cnt_ff, nxt_kill_cnt;
   logic kill_latch_ff, nxt_kill_latch;
   logic kill_act_ff, nxt_kill_act;
   logic [CW-1:0] per_cnt_ff, nxt_per_cnt;
   logic hot_ff, nxt_hot;
   logic [CW-1:0] rel_cnt_ff, nxt_rel_cnt;
   logic [CW-1:0] al_cnt_ff, nxt_al_cnt;
   logic ot_trip_ff, nxt_ot_trip;
   logic vin_d_ff, nxt_vin_d;
   // registered outputs
   logic sw_ff, nxt_sw;
   logic inr_ff, nxt_inr;
   logic dis_ff, nxt_dis;
   logic bias_ff, nxt_bias;
   logic alert_ff, nxt_alert;
   logic bdn_ff, nxt_bdn;
   logic bsel_ff, nxt_bsel;

   logic fault_any;
   logic kill_open;

   // a coarse tick keeps every interval counter narrow
   always_comb begin
      nxt_tick = 1'b0;
      nxt_pre = pre_ff + 1'b1;
      if (pre_ff == CW'(TICK_CYC - 1)) begin
         nxt_pre = '0;
         nxt_tick = 1'b1;
      end
   end

   // thermistor sampling, request debounce and battery disconnect
   always_comb begin
      nxt_per_cnt = per_cnt_ff;
      nxt_hot = hot_ff;
      nxt_rel_cnt = rel_cnt_ff;
      nxt_al_cnt = al_cnt_ff;
      nxt_ot_trip = ot_trip_ff;
      nxt_kill_cnt = kill_cnt_ff;
      nxt_kill_latch = kill_latch_ff;
      nxt_kill_act = kill_act_ff;
      nxt_vin_d = sense.vin_valid;
      nxt_bias = 1'b1;
      if (!sense.vin_valid) begin
         nxt_bias = (per_cnt_ff < CW'(BIAS_T));
      end
      if (tick_ff) begin
         nxt_per_cnt = (per_cnt_ff == CW'(PER_T - 1)) ? '0 : per_cnt_ff + 1'b1;
         // sample once per period on battery, every tick once settled on input
         if ((sense.vin_valid && per_cnt_ff >= CW'(SET_T)) || per_cnt_ff == CW'(SET_T)) begin
            if (thermistor_inputs) begin
               nxt_hot = 1'b1;
               nxt_rel_cnt = '0;
            end else if (hot_ff) begin
               // on battery each sample is a period apart, so one clean sample releases
               if (!sense.vin_valid || rel_cnt_ff >= CW'(REL_T)) begin
                  nxt_hot = 1'b0;
               end
            end
         end
         if (hot_ff && !thermistor_inputs && rel_cnt_ff < CW'(REL_T)) begin
            nxt_rel_cnt = rel_cnt_ff + 1'b1;
         end
         if (hot_ff) begin
            if (al_cnt_ff >= CW'(ALERT_T - 1)) begin
               nxt_ot_trip = 1'b1;
            end else begin
               nxt_al_cnt = al_cnt_ff + 1'b1;
            end
         end
         if (alert_pin_in && !alert_ff && !hot_ff) begin
            if (kill_cnt_ff >= CW'(KILL_T - 1)) begin
               nxt_kill_act = 1'b1;
               if (sense.vin_valid) begin
                  nxt_kill_latch = 1'b1;
               end
            end else begin
               nxt_kill_cnt = kill_cnt_ff + 1'b1;
            end
         end
      end
      if (!hot_ff) begin
         nxt_al_cnt = '0;
         nxt_ot_trip = 1'b0;
      end
      if (!alert_pin_in || alert_ff) begin
         nxt_kill_cnt = '0;
         nxt_kill_act = 1'b0;
      end
      if (vin_d_ff && !sense.vin_valid) begin
         nxt_kill_latch = 1'b0;
      end
   end

   assign kill_open = kill_latch_ff || kill_act_ff;
   assign fault_any = sense.brownout || sense.overvolt || sense.junction_hot || sense.hard_short
                      || ot_trip_ff || kill_open;

   // switch sequencer
   always_comb begin
      nxt_st = st_ff;
      nxt_seq_cnt = seq_cnt_ff;
      nxt_was_brownout = was_brownout_ff;
      if (tick_ff && seq_cnt_ff != '0) begin
         nxt_seq_cnt = seq_cnt_ff - 1'b1;
      end
      case (st_ff)
         pss_pkg::PSS_OFF: begin
            nxt_st = pss_pkg::PSS_DELAY;
            nxt_seq_cnt = CW'(TON_T);
         end
         pss_pkg::PSS_DELAY: begin
            // faults ignored until the count runs out
            if (seq_cnt_ff == '0) begin
               nxt_st = fault_any ? pss_pkg::PSS_FAULT : pss_pkg::PSS_ON;
            end
         end
         pss_pkg::PSS_ON: begin
            if (fault_any) begin
               nxt_st = pss_pkg::PSS_FAULT;
            end
         end
         pss_pkg::PSS_FAULT: begin
            nxt_was_brownout = sense.brownout;
            if (!fault_any) begin
               nxt_st = pss_pkg::PSS_REC;
               nxt_seq_cnt = was_brownout_ff ? CW'(REC_T) : '0;
            end
         end
         pss_pkg::PSS_REC: begin
            if (fault_any) begin
               nxt_st = pss_pkg::PSS_FAULT;
            end else if (seq_cnt_ff == '0) begin
               nxt_st = pss_pkg::PSS_ON;
            end
         end
         default: nxt_st = pss_pkg::PSS_OFF;
      endcase
      if (!sense.vin_valid) begin
         nxt_st = pss_pkg::PSS_OFF;
         nxt_seq_cnt = '0;
      end
   end

   always_comb begin
      nxt_sw = (nxt_st == pss_pkg::PSS_ON);
      nxt_inr = nxt_sw && !sw_ff ? 1'b1 : (inr_ff && nxt_sw && !tick_ff);
      // OV, junction heat and short leave discharge off
      nxt_dis = (nxt_st == pss_pkg::PSS_FAULT && (sense.brownout || ot_trip_ff || kill_open)
                 && !sense.overvolt && !sense.junction_hot && !sense.hard_short)
                || (!sense.vin_valid);
      nxt_alert = hot_ff;
      nxt_bdn = ot_trip_ff || kill_open;
      nxt_bsel = !sense.vin_valid;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         pre_ff <= nxt_pre;
         tick_ff <= nxt_tick;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         kill_cnt_ff <= '0;
         kill_latch_ff <= 1'b0;
         kill_act_ff <= 1'b0;
         per_cnt_ff <= '0;
         hot_ff <= 1'b0;
         rel_cnt_ff <= '0;
         al_cnt_ff <= '0;
         ot_trip_ff <= 1'b0;
         vin_d_ff <= 1'b0;
         bias_ff <= 1'b0;
      end else begin
         kill_cnt_ff <= nxt_kill_cnt;
         kill_latch_ff <= nxt_kill_latch;
         kill_act_ff <= nxt_kill_act;
         per_cnt_ff <= nxt_per_cnt;
         hot_ff <= nxt_hot;
         rel_cnt_ff <= nxt_rel_cnt;
         al_cnt_ff <= nxt_al_cnt;
         ot_trip_ff <= nxt_ot_trip;
         vin_d_ff <= nxt_vin_d;
         bias_ff <= nxt_bias;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= pss_pkg::PSS_OFF;
         seq_cnt_ff <= '0;
         was_brownout_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         seq_cnt_ff <= nxt_seq_cnt;
         was_brownout_ff <= nxt_was_brownout;
      end
   end

   // selector resets to the battery: no input has been proven valid yet
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_ff <= 1'b0;
         inr_ff <= 1'b0;
         dis_ff <= 1'b0;
         alert_ff <= 1'b0;
         bdn_ff <= 1'b0;
         bsel_ff <= 1'b1;
      end else begin
         sw_ff <= nxt_sw;
         inr_ff <= nxt_inr;
         dis_ff <= nxt_dis;
         alert_ff <= nxt_alert;
         bdn_ff <= nxt_bdn;
         bsel_ff <= nxt_bsel;
      end
   end

   assign switch_close = sw_ff;
   assign inrush_limit = inr_ff;
   assign out_discharge = dis_ff;
   assign in_discharge = dis_ff;
   assign sensor_bias_rail = bias_ff;
   assign battery_selected = bsel_ff;
   assign alert_pin_out = alert_ff;
   assign alert_pin_oe = alert_ff;
   assign battery_disconnect_n_out = 1'b0;
   assign battery_disconnect_n_oe = bdn_ff;
endmodule

// file: logic/pss_cfg.svh
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH
`define PSS_CLK_KHZ 200000
`define PSS_TON_MS 20
`define PSS_REC_MS 500
`define PSS_KILL_MS 1000
`define PSS_ALERT_MS 500
`define PSS_REL_MS 50
`define PSS_PERIOD_US 2500000
`define PSS_BIAS_ON_US 5000
`define PSS_SETTLE_US 1600
`define PSS_TICK_US 100
`define PSS_TICK_CYC (`PSS_TICK_US * `PSS_CLK_KHZ / 1000)
`endif

// file: logic/pss_pkg.sv
package pss_pkg;
   typedef enum logic [2:0] {
      PSS_OFF = 3'b000,
      PSS_DELAY = 3'b001,
      PSS_ON = 3'b011,
      PSS_REC = 3'b010,
      PSS_FAULT = 3'b110
   } pss_state_e;
   typedef struct packed {
      logic vin_valid;
      logic brownout;
      logic overvolt;
      logic junction_hot;
      logic hard_short;
   } pss_sense_s;
endpackage

// file: test/pss_host_model.sv
`timescale 1ns/1ps
module pss_host_model (
   // host side request
   input wire logic req_en,
   // device pin drivers
   input wire logic alert_pin_out,
   input wire logic alert_pin_oe,
   input wire logic battery_disconnect_n_out,
   input wire logic battery_disconnect_n_oe,
   // resolved wires
   output logic alert_line,
   output logic disconnect_line
);
   // weak pulldown on the shared pin, host drives it high only to request power-off
   assign alert_line = alert_pin_oe ? alert_pin_out : req_en;
   // external pull-up holds the line high while released
   assign disconnect_line = battery_disconnect_n_oe ? battery_disconnect_n_out : 1'b1;
endmodule

// file: test/pss_sequencer_props.sv
`timescale 1ns/1ps
`include "pss_cfg.svh"
module pss_sequencer_props #(
   parameter int TICK_CYC = `PSS_TICK_CYC,
   parameter int TICK_US = `PSS_TICK_US
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire pss_pkg::pss_sense_s sense,
   input wire logic thermistor_inputs,
   input wire logic alert_pin_in,
   input wire logic alert_pin_out,
   input wire logic alert_pin_oe,
   input wire logic battery_disconnect_n_out,
   input wire logic battery_disconnect_n_oe,
   input wire logic switch_close,
   input wire logic inrush_limit,
   input wire logic out_discharge,
   input wire logic in_discharge,
   input wire logic sensor_bias_rail,
   input wire logic battery_selected
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence s_power_up;
      !sense.vin_valid [*3] ##1 sense.vin_valid;
   endsequence
   sequence s_brownout_hit;
      sense.brownout && switch_close && !sense.overvolt && !sense.junction_hot && !sense.hard_short;
   endsequence
   sequence s_ov_trip;
      switch_close && sense.overvolt && sense.vin_valid && !sense.brownout && !thermistor_inputs && !alert_pin_in;
   endsequence
   turn_on_wait_a: assert property (s_power_up |=> !switch_close [*8]) else $error("early close");
   inrush_start_a: assert property ($rose(switch_close) |-> inrush_limit) else $error("no inrush");
   brownout_open_a: assert property (s_brownout_hit |-> ##[1:3] (!switch_close && out_discharge))
      else $error("brownout not handled");
   ov_open_a: assert property (s_ov_trip |-> ##[1:3] (!switch_close && !out_discharge))
      else $error("overvoltage not handled");
   dis_pair_a: assert property (out_discharge |-> in_discharge) else $error("input discharge off");
   supply_pick_a: assert property (sense.vin_valid |=> !battery_selected) else $error("wrong supply");
   input_off_a: assert property (!sense.vin_valid [*3] |-> !switch_close) else $error("closed without input");
   od_low_a: assert property (battery_disconnect_n_oe |-> !battery_disconnect_n_out) else $error("od high");
   disc_cause_a: assert property ($rose(battery_disconnect_n_oe) |-> alert_pin_in || $past(alert_pin_in))
      else $error("disconnect without cause");
   bias_steady_a: assert property (sense.vin_valid [*3] |-> sensor_bias_rail) else $error("bias off");
   alert_drive_a: assert property (alert_pin_oe |-> alert_pin_out) else $error("alert low");
endmodule
bind pss_sequencer pss_sequencer_props #(.TICK_CYC(TICK_CYC), .TICK_US(TICK_US)) u_props (
   .core_clk(core_clk), .rst_b(rst_b), .sense(sense), .thermistor_inputs(thermistor_inputs),
   .alert_pin_in(alert_pin_in), .alert_pin_out(alert_pin_out), .alert_pin_oe(alert_pin_oe),
   .battery_disconnect_n_out(battery_disconnect_n_out), .battery_disconnect_n_oe(battery_disconnect_n_oe),
   .switch_close(switch_close), .inrush_limit(inrush_limit), .out_discharge(out_discharge),
   .in_discharge(in_discharge), .sensor_bias_rail(sensor_bias_rail), .battery_selected(battery_selected));

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
   logic core_clk, rst_b, therm, req_en, alert_line, disc_line;
   logic a_out, a_oe, d_out, d_oe, sw, inr, odis, idis, bias, bsel;
   pss_pkg::pss_sense_s sense;
   int miscompares, n_checks, n;
   // {expected discharge, vin_valid, brownout, overvolt, junction_hot, hard_short}, vin_valid set in every row
   logic [5:0] rows [4] = '{6'h38, 6'h14, 6'h12, 6'h11};
   pss_sequencer #(.TICK_CYC(4), .TICK_US(100)) u_dut (.core_clk(core_clk), .rst_b(rst_b), .sense(sense),
      .thermistor_inputs(therm), .alert_pin_in(alert_line), .alert_pin_out(a_out), .alert_pin_oe(a_oe),
      .battery_disconnect_n_out(d_out), .battery_disconnect_n_oe(d_oe), .switch_close(sw), .inrush_limit(inr),
      .out_discharge(odis), .in_discharge(idis), .sensor_bias_rail(bias), .battery_selected(bsel));
   pss_host_model u_host (.req_en(req_en), .alert_pin_out(a_out), .alert_pin_oe(a_oe),
      .battery_disconnect_n_out(d_out), .battery_disconnect_n_oe(d_oe), .alert_line(alert_line),
      .disconnect_line(disc_line));
   initial begin
      core_clk = 0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // counts negedges until the level shows, so samples never race the design's flops
   task automatic wait_lvl(ref logic s, input logic v, input int lim);
      n = 0;
      while (s !== v && n < lim) begin
         @(negedge core_clk);
         n++;
      end
      @(posedge core_clk);
   endtask
   task automatic tally_and_finish();
      if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (95000) @(posedge core_clk);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      rst_b = 0;
      sense = '0;
      therm = 0;
      req_en = 0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1;
      @(negedge core_clk);
      check({bsel, sw, d_oe, odis}, 4'h8);
      @(negedge core_clk);
      check(odis, 1);
      @(posedge core_clk);
      sense <= 5'h10;
      wait_lvl(sw, 1'b1, 2000);
      check(n >= 794 && n <= 806, 1);
      check({inr, bias, bsel}, 3'h6);
      foreach (rows[i]) begin
         sense <= pss_pkg::pss_sense_s'(rows[i][4:0]);
         repeat (4) @(negedge core_clk);
         check({sw, odis, idis}, {1'b0, {2{rows[i][5]}}});
         @(posedge core_clk);
         sense <= 5'h10;
         wait_lvl(sw, 1'b1, 25000);
         check(sw, 1);
         if (rows[i][5]) check(n > 19990, 1);
      end
      req_en <= 1;
      wait_lvl(d_oe, 1'b1, 41000);
      check(n >= 39994 && n <= 40006, 1);
      req_en <= 0;
      repeat (8) @(negedge core_clk);
      check({sw, disc_line}, 2'h0);
      @(posedge core_clk);
      sense <= 5'h00;
      repeat (8) @(negedge core_clk);
      check({bsel, d_oe, odis, bias}, 4'hA);
      @(posedge core_clk);
      sense <= 5'h10;
      wait_lvl(sw, 1'b1, 2000);
      therm <= 1;
      wait_lvl(a_oe, 1'b1, 2000);
      check({alert_line, d_oe}, 2'h2);
      wait_lvl(d_oe, 1'b1, 21000);
      check(n >= 19994 && n <= 20006, 1);
      check({sw, disc_line}, 2'h0);
      therm <= 0;
      wait_lvl(d_oe, 1'b0, 3000);
      check(n >= 1990, 1);
      check({disc_line, a_oe}, 2'h2);
      tally_and_finish();
   end
endmodule
